// >>> core/aic_map.vh
`ifndef AIC_MAP_VH
`define AIC_MAP_VH

// timing
`define AIC_CLK_MHZ 125
`define AIC_SAMPLE_US 1000
`define AIC_SAMPLE_CYC (`AIC_SAMPLE_US * `AIC_CLK_MHZ)

// signal levels, 0.01 % per lsb
`define AIC_FULL_SCALE 16'sh2710
`define AIC_LIVE_ZERO 16'sh07d0
`define AIC_ZERO 16'sh0000

// range selection codes
`define AIC_RNG_FULL 2'h0
`define AIC_RNG_LIVE 2'h1
`define AIC_RNG_BIPOLAR 2'h2
`define AIC_RNG_CUSTOM 2'h3

// byte offsets
`define AIC_OFS_CTRL 12'h000
`define AIC_OFS_FILT 12'h004
`define AIC_OFS_CUST1 12'h008
`define AIC_OFS_CUST2 12'h00c
`define AIC_OFS_CUST3 12'h010
`define AIC_OFS_CUST4 12'h014
`define AIC_OFS_REF1 12'h018
`define AIC_OFS_REF2 12'h01c
`define AIC_OFS_DEADB 12'h020
`define AIC_OFS_SLPLIM 12'h024
`define AIC_OFS_SLPDLY 12'h028
`define AIC_OFS_TGTID 12'h02c
`define AIC_OFS_TGT3LO 12'h030
`define AIC_OFS_TGT3HI 12'h034
`define AIC_OFS_TGT4LO 12'h038
`define AIC_OFS_TGT4HI 12'h03c
`define AIC_OFS_CMD 12'h040
`define AIC_OFS_JOYOFS 12'h044
`define AIC_OFS_STATUS 12'h048
`define AIC_OFS_MON 12'h04c

// register array indexes
`define AIC_IDX_CTRL 4'h0
`define AIC_IDX_FILT 4'h1
`define AIC_IDX_CUST1 4'h2
`define AIC_IDX_REF1 4'h6
`define AIC_IDX_REF2 4'h7
`define AIC_IDX_DEADB 4'h8
`define AIC_IDX_SLPLIM 4'h9
`define AIC_IDX_SLPDLY 4'ha
`define AIC_IDX_TGTID 4'hb
`define AIC_IDX_TGT3LO 4'hc
`define AIC_IDX_TGT3HI 4'hd
`define AIC_IDX_TGT4LO 4'he
`define AIC_IDX_TGT4HI 4'hf
`define AIC_NCFG 16

// ctrl fields
`define AIC_CTRL_RNG1 1:0
`define AIC_CTRL_RNG2 3:2
`define AIC_CTRL_JOY1 4
`define AIC_CTRL_JOY2 5
`define AIC_CTRL_SLPEN1 6
`define AIC_CTRL_SLPEN2 7
`define AIC_CTRL_SPDSEL 8
`define AIC_CTRL_SRC3 9
`define AIC_CTRL_SRC4 10
`define AIC_CTRL_INV3 11
`define AIC_CTRL_INV4 12

// cmd fields
`define AIC_CMD_CAP1 0
`define AIC_CMD_CAP2 1
`define AIC_CMD_CLR1 2
`define AIC_CMD_CLR2 3

// reset values
`define AIC_RST_SPAN 32'h27100000
`define AIC_RST_ZERO 32'h00000000

`endif

// >>> core/aic_lpf.v
// first-order low-pass: y += (x - y) >>> shift once per sample tick
module aic_lpf (
	input wire clk_sys,
	input wire rst,
	input wire sampleTick,
	input wire [3:0] shift,
	input wire signed [15:0] din,
	output wire signed [15:0] dout
);
	reg signed [31:0] acc_ff;
	reg signed [31:0] nxt_acc;
	wire signed [31:0] target;

	// 16 fraction bits keep long time constants from stalling on rounding
	assign target = {din, 16'h0000};
	assign dout = acc_ff[31:16];

	// shift 0 passes the input straight through
	always @*
	begin
		nxt_acc = acc_ff + ((target - acc_ff) >>> shift);
	end

	// state only moves on the sample enable
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			acc_ff <= 32'sh00000000;
		else if (sampleTick)
			acc_ff <= nxt_acc;
	end
endmodule // aic_lpf

// >>> core/aic_top.v
`include "aic_map.vh"
module aic_top #(
	parameter SAMPLE_CYCLES = `AIC_SAMPLE_CYC
) (
	input wire clk_sys,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire signed [15:0] chanOneRaw,
	input wire signed [15:0] chanTwoRaw,
	input wire signed [15:0] chanThreeRaw,
	input wire signed [15:0] chanFourRaw,
	input wire signed [15:0] fbThree,
	input wire signed [15:0] fbFour,
	output wire signed [15:0] monOne,
	output wire signed [15:0] monTwo,
	output wire signed [15:0] limitOne,
	output wire signed [15:0] limitTwo,
	output wire signed [15:0] speedRef,
	output wire sleepStop,
	output wire [15:0] tgtThreeId,
	output wire signed [31:0] tgtThreeValue,
	output wire tgtThreeWrite,
	output wire [15:0] tgtFourId,
	output wire signed [31:0] tgtFourValue,
	output wire tgtFourWrite
);
	reg [31:0] cfg_ff [0:`AIC_NCFG-1];
	reg [31:0] prdata_ff;
	reg [31:0] divCnt_ff;
	reg sampleTick_ff;
	reg signed [15:0] metaOne_ff, metaTwo_ff, metaThree_ff, metaFour_ff;
	reg signed [15:0] syncOne_ff, syncTwo_ff, syncThree_ff, syncFour_ff;
	reg signed [15:0] joyOfsOne_ff, joyOfsTwo_ff;
	reg [15:0] slpCntOne_ff, slpCntTwo_ff;
	reg signed [15:0] monOne_ff, monTwo_ff;
	reg signed [31:0] tgtThree_ff, tgtFour_ff;
	reg tgtWrite_ff;
	reg [31:0] nxt_prdata;
	integer i;

	wire [31:0] ctrl = cfg_ff[`AIC_IDX_CTRL];
	wire [31:0] filt = cfg_ff[`AIC_IDX_FILT];
	wire cfgHit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
	wire roHit = (paddr == `AIC_OFS_JOYOFS) || (paddr == `AIC_OFS_STATUS) ||
		(paddr == `AIC_OFS_MON);
	wire cmdHit = (paddr == `AIC_OFS_CMD);
	wire accessEn = psel && penable;
	wire wrCfg = accessEn && pwrite && cfgHit;
	wire wrCmd = accessEn && pwrite && cmdHit;

	// linear map of [inLo,inHi] onto [outLo,outHi]; a reversed span just slopes down
	function signed [63:0] mapLin(input signed [63:0] x, input signed [63:0] inLo,
		input signed [63:0] inHi, input signed [63:0] outLo, input signed [63:0] outHi);
		reg signed [63:0] den;
		begin
			den = inHi - inLo;
			if (den == 64'sh0)
				mapLin = outLo;
			else
				mapLin = outLo + ((x - inLo) * (outHi - outLo)) / den;
		end
	endfunction

	// clamp to a window that fits 16 bits
	function signed [15:0] clamp(input signed [63:0] v, input signed [63:0] lo,
		input signed [63:0] hi);
		begin
			if (v < lo)
				clamp = lo[15:0];
			else if (v > hi)
				clamp = hi[15:0];
			else
				clamp = v[15:0];
		end
	endfunction

	// range selection front end shared by channels 1 and 2
	function signed [15:0] condRange(input signed [15:0] x, input [1:0] sel,
		input [31:0] span);
		begin
			case (sel)
				`AIC_RNG_FULL:
					condRange = clamp(x, `AIC_ZERO, `AIC_FULL_SCALE);
				`AIC_RNG_LIVE:
					condRange = clamp(mapLin(x, `AIC_LIVE_ZERO, `AIC_FULL_SCALE, `AIC_ZERO,
						`AIC_FULL_SCALE), `AIC_ZERO, `AIC_FULL_SCALE);
				`AIC_RNG_BIPOLAR:
					condRange = clamp(x, -`AIC_FULL_SCALE, `AIC_FULL_SCALE);
				default:
					condRange = clamp(mapLin(x, $signed(span[15:0]), $signed(span[31:16]),
						`AIC_ZERO, `AIC_FULL_SCALE), -16'sh7fff, 16'sh7fff);
			endcase
		end
	endfunction

	// offset, reference scaling and dead band of one channel
	function signed [15:0] refChain(input signed [15:0] cond, input signed [15:0] ofs,
		input [31:0] refSpan, input signed [15:0] band);
		reg signed [15:0] scaled;
		begin
			// offset moves the zero point, scaling itself is left alone
			scaled = clamp(mapLin(cond - ofs, `AIC_ZERO, `AIC_FULL_SCALE,
				$signed(refSpan[15:0]), $signed(refSpan[31:16])),
				-16'sh7fff, 16'sh7fff);
			if (band != `AIC_ZERO && scaled < band && scaled > -band)
				refChain = `AIC_ZERO;
			else
				refChain = scaled;
		end
	endfunction

	// sleep window test, symmetric around zero in joystick use
	function belowSleep(input signed [15:0] v, input signed [15:0] lim, input joy);
		begin
			if (joy)
				belowSleep = (v < lim) && (v > -lim);
			else
				belowSleep = (v < lim);
		end
	endfunction

	// channel 3/4 custom span, clamped to zero..full scale, optional inversion
	function signed [15:0] customInv(input signed [15:0] x, input [31:0] span, input inv);
		reg signed [15:0] c;
		begin
			c = clamp(mapLin(x, $signed(span[15:0]), $signed(span[31:16]), `AIC_ZERO,
				`AIC_FULL_SCALE), `AIC_ZERO, `AIC_FULL_SCALE);
			customInv = inv ? (`AIC_FULL_SCALE - c) : c;
		end
	endfunction

	// conditioning datapath
	wire signed [15:0] condOne = condRange(syncOne_ff, ctrl[`AIC_CTRL_RNG1],
		cfg_ff[`AIC_IDX_CUST1]);
	wire signed [15:0] condTwo = condRange(syncTwo_ff, ctrl[`AIC_CTRL_RNG2],
		cfg_ff[`AIC_IDX_CUST1 + 4'h1]);
	wire signed [15:0] refOne = refChain(condOne, joyOfsOne_ff, cfg_ff[`AIC_IDX_REF1],
		cfg_ff[`AIC_IDX_DEADB][15:0]);
	wire signed [15:0] refTwo = refChain(condTwo, joyOfsTwo_ff, cfg_ff[`AIC_IDX_REF2],
		cfg_ff[`AIC_IDX_DEADB][31:16]);
	// one reference is picked first so only it pays for the second-order stage
	wire signed [15:0] speedSrc = ctrl[`AIC_CTRL_SPDSEL] ? refTwo : refOne;
	wire [3:0] spdShift = ctrl[`AIC_CTRL_SPDSEL] ? filt[7:4] : filt[3:0];
	wire signed [15:0] srcThree = ctrl[`AIC_CTRL_SRC3] ? fbThree : syncThree_ff;
	wire signed [15:0] srcFour = ctrl[`AIC_CTRL_SRC4] ? fbFour : syncFour_ff;
	wire signed [15:0] speedMid, filtThree, filtFour;
	wire signed [15:0] invThree = customInv(filtThree, cfg_ff[`AIC_IDX_CUST1 + 4'h2],
		ctrl[`AIC_CTRL_INV3]);
	wire signed [15:0] invFour = customInv(filtFour, cfg_ff[`AIC_IDX_CUST1 + 4'h3],
		ctrl[`AIC_CTRL_INV4]);
	wire signed [63:0] mapThree = mapLin(invThree, `AIC_ZERO, `AIC_FULL_SCALE,
		$signed(cfg_ff[`AIC_IDX_TGT3LO]), $signed(cfg_ff[`AIC_IDX_TGT3HI]));
	wire signed [63:0] mapFour = mapLin(invFour, `AIC_ZERO, `AIC_FULL_SCALE,
		$signed(cfg_ff[`AIC_IDX_TGT4LO]), $signed(cfg_ff[`AIC_IDX_TGT4HI]));
	wire lowOne = belowSleep(condOne, cfg_ff[`AIC_IDX_SLPLIM][15:0], ctrl[`AIC_CTRL_JOY1]);
	wire lowTwo = belowSleep(condTwo, cfg_ff[`AIC_IDX_SLPLIM][31:16], ctrl[`AIC_CTRL_JOY2]);
	wire [15:0] dlyOne = cfg_ff[`AIC_IDX_SLPDLY][15:0];
	wire [15:0] dlyTwo = cfg_ff[`AIC_IDX_SLPDLY][31:16];
	wire sleepOne = ctrl[`AIC_CTRL_SLPEN1] && lowOne && (slpCntOne_ff >= dlyOne);
	wire sleepTwo = ctrl[`AIC_CTRL_SLPEN2] && lowTwo && (slpCntTwo_ff >= dlyTwo);

	// limit paths, first order only
	aic_lpf u_limOne (.clk_sys(clk_sys), .rst(rst), .sampleTick(sampleTick_ff),
		.shift(filt[3:0]), .din(refOne), .dout(limitOne));
	aic_lpf u_limTwo (.clk_sys(clk_sys), .rst(rst), .sampleTick(sampleTick_ff),
		.shift(filt[7:4]), .din(refTwo), .dout(limitTwo));
	// speed path: two cascaded stages form the second-order filter
	aic_lpf u_spdA (.clk_sys(clk_sys), .rst(rst), .sampleTick(sampleTick_ff),
		.shift(spdShift), .din(speedSrc), .dout(speedMid));
	aic_lpf u_spdB (.clk_sys(clk_sys), .rst(rst), .sampleTick(sampleTick_ff),
		.shift(spdShift), .din(speedMid), .dout(speedRef));
	aic_lpf u_fltThree (.clk_sys(clk_sys), .rst(rst), .sampleTick(sampleTick_ff),
		.shift(filt[11:8]), .din(srcThree), .dout(filtThree));
	aic_lpf u_fltFour (.clk_sys(clk_sys), .rst(rst), .sampleTick(sampleTick_ff),
		.shift(filt[15:12]), .din(srcFour), .dout(filtFour));

	// zero-wait slave; read data is latched in the setup cycle
	assign pready = 1'b1;
	assign pslverr = accessEn && !(cfgHit || cmdHit || (roHit && !pwrite));
	assign prdata = prdata_ff;
	assign monOne = monOne_ff;
	assign monTwo = monTwo_ff;
	assign sleepStop = sleepOne || sleepTwo;
	assign tgtThreeId = cfg_ff[`AIC_IDX_TGTID][15:0];
	assign tgtFourId = cfg_ff[`AIC_IDX_TGTID][31:16];
	assign tgtThreeValue = tgtThree_ff;
	assign tgtFourValue = tgtFour_ff;
	assign tgtThreeWrite = tgtWrite_ff;
	assign tgtFourWrite = tgtWrite_ff;

	// read mux; unmapped and command addresses read zero
	always @*
	begin
		nxt_prdata = 32'h00000000;
		if (cfgHit)
			nxt_prdata = cfg_ff[paddr[5:2]];
		else if (paddr == `AIC_OFS_JOYOFS)
			nxt_prdata = {joyOfsTwo_ff, joyOfsOne_ff};
		else if (paddr == `AIC_OFS_STATUS)
			nxt_prdata = {29'h00000000, sleepStop, sleepTwo, sleepOne};
		else if (paddr == `AIC_OFS_MON)
			nxt_prdata = {monTwo_ff, monOne_ff};
	end

	// bus registers and joystick offsets
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			for (i = 0; i < `AIC_NCFG; i = i + 1)
				cfg_ff[i] <= `AIC_RST_ZERO;
			cfg_ff[`AIC_IDX_CUST1] <= `AIC_RST_SPAN;
			cfg_ff[`AIC_IDX_CUST1 + 4'h1] <= `AIC_RST_SPAN;
			cfg_ff[`AIC_IDX_CUST1 + 4'h2] <= `AIC_RST_SPAN;
			cfg_ff[`AIC_IDX_CUST1 + 4'h3] <= `AIC_RST_SPAN;
			cfg_ff[`AIC_IDX_REF1] <= `AIC_RST_SPAN;
			cfg_ff[`AIC_IDX_REF2] <= `AIC_RST_SPAN;
			prdata_ff <= 32'h00000000;
			joyOfsOne_ff <= 16'sh0000;
			joyOfsTwo_ff <= 16'sh0000;
		end
		else
		begin
			if (psel && !penable)
				prdata_ff <= nxt_prdata;
			if (wrCfg)
				cfg_ff[paddr[5:2]] <= pwdata;
			// a clear in the same write overrides a capture
			if (wrCmd && pwdata[`AIC_CMD_CLR1])
				joyOfsOne_ff <= 16'sh0000;
			else if (wrCmd && pwdata[`AIC_CMD_CAP1])
				joyOfsOne_ff <= condOne;
			if (wrCmd && pwdata[`AIC_CMD_CLR2])
				joyOfsTwo_ff <= 16'sh0000;
			else if (wrCmd && pwdata[`AIC_CMD_CAP2])
				joyOfsTwo_ff <= condTwo;
		end
	end

	// terminal words cross in through two flops; words are assumed slow vs the clock
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			metaOne_ff <= 16'sh0000;
			metaTwo_ff <= 16'sh0000;
			metaThree_ff <= 16'sh0000;
			metaFour_ff <= 16'sh0000;
			syncOne_ff <= 16'sh0000;
			syncTwo_ff <= 16'sh0000;
			syncThree_ff <= 16'sh0000;
			syncFour_ff <= 16'sh0000;
		end
		else
		begin
			metaOne_ff <= chanOneRaw;
			metaTwo_ff <= chanTwoRaw;
			metaThree_ff <= chanThreeRaw;
			metaFour_ff <= chanFourRaw;
			syncOne_ff <= metaOne_ff;
			syncTwo_ff <= metaTwo_ff;
			syncThree_ff <= metaThree_ff;
			syncFour_ff <= metaFour_ff;
		end
	end

	// sample divider, sleep timers and sampled outputs
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			divCnt_ff <= 32'h00000000;
			sampleTick_ff <= 1'b0;
			slpCntOne_ff <= 16'h0000;
			slpCntTwo_ff <= 16'h0000;
			monOne_ff <= 16'sh0000;
			monTwo_ff <= 16'sh0000;
			tgtThree_ff <= 32'sh00000000;
			tgtFour_ff <= 32'sh00000000;
			tgtWrite_ff <= 1'b0;
		end
		else
		begin
			sampleTick_ff <= (divCnt_ff == SAMPLE_CYCLES - 1);
			divCnt_ff <= (divCnt_ff == SAMPLE_CYCLES - 1) ? 32'h00000000 : divCnt_ff + 32'h1;
			tgtWrite_ff <= sampleTick_ff;
			if (sampleTick_ff)
			begin
				monOne_ff <= condOne;
				monTwo_ff <= condTwo;
				tgtThree_ff <= mapThree[31:0];
				tgtFour_ff <= mapFour[31:0];
				// a single sample above the limit restarts the wait
				if (!lowOne)
					slpCntOne_ff <= 16'h0000;
				else if (slpCntOne_ff != 16'hffff)
					slpCntOne_ff <= slpCntOne_ff + 16'h1;
				if (!lowTwo)
					slpCntTwo_ff <= 16'h0000;
				else if (slpCntTwo_ff != 16'hffff)
					slpCntTwo_ff <= slpCntTwo_ff + 16'h1;
			end
		end
	end
endmodule // aic_top

// >>> dv/aic_checker.sv
module aic_checker #(
	parameter SAMPLE_CYCLES = 8
) (
	input wire clk_sys,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire [15:0] tgtThreeId,
	input wire signed [31:0] tgtThreeValue,
	input wire tgtThreeWrite,
	input wire tgtFourWrite
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] gap_ff;
	logic seen_ff;
	wire access = psel && penable;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// cycles since the last write pulse; a counter avoids a long repetition
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			gap_ff <= 32'h0;
			seen_ff <= 1'b0;
		end
		else
		begin
			gap_ff <= tgtThreeWrite ? 32'h0 : gap_ff + 32'h1;
			seen_ff <= seen_ff | tgtThreeWrite;
		end
	end
	sequence s_pulse;
		tgtThreeWrite ##1 !tgtThreeWrite;
	endsequence
	sequence s_idWrite;
		access && pwrite && paddr == 12'h02c;
	endsequence
	a_pready_high: assert property (access |-> pready)
		else $error("pready low in access phase");
	a_err_in_access: assert property (pslverr |-> access)
		else $error("pslverr outside access phase");
	a_bad_address: assert property (access && paddr > 12'h04c |-> pslverr)
		else $error("unmapped address not refused");
	a_unaligned_err: assert property (access && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned address not refused");
	a_ro_write: assert property (access && pwrite && paddr[1:0] == 2'h0
		&& paddr >= 12'h044 && paddr <= 12'h04c |-> pslverr)
		else $error("write to read-only register not refused");
	a_pulse_pair: assert property (tgtThreeWrite == tgtFourWrite)
		else $error("target write pulses differ");
	a_pulse_single: assert property ($rose(tgtThreeWrite) |-> s_pulse)
		else $error("target write pulse longer than one cycle");
	a_pulse_period: assert property (tgtThreeWrite && seen_ff
		|-> gap_ff == SAMPLE_CYCLES - 1)
		else $error("target write period wrong");
	a_value_held: assert property ($changed(tgtThreeValue) |-> ##[0:1] tgtThreeWrite)
		else $error("target value changed between pulses");
	a_id_from_reg: assert property (s_idWrite |=> tgtThreeId == $past(pwdata[15:0]))
		else $error("target id does not follow register");
endmodule // aic_checker

bind aic_top aic_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk (.clk_sys(clk_sys), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .tgtThreeId(tgtThreeId),
	.tgtThreeValue(tgtThreeValue), .tgtThreeWrite(tgtThreeWrite), .tgtFourWrite(tgtFourWrite));

// >>> dv/aic_sense_model.sv
module aic_sense_model (
	input wire clk_sys,
	output wire signed [15:0] rawOne,
	output wire signed [15:0] rawTwo,
	output wire signed [15:0] rawThree,
	output wire signed [15:0] rawFour,
	output wire signed [15:0] fbThree,
	output wire signed [15:0] fbFour
);
	timeunit 1ns;
	timeprecision 1ps;
	logic signed [15:0] lvl [0:5] = '{default: 16'sh0};
	// levels move only right after a clock edge, like a plc update
	task automatic setLevel(input int ch, input logic signed [15:0] v);
		@(posedge clk_sys);
		lvl[ch] <= v;
	endtask
	// four terminals then two process data words
	assign rawOne = lvl[0];
	assign rawTwo = lvl[1];
	assign rawThree = lvl[2];
	assign rawFour = lvl[3];
	assign fbThree = lvl[4];
	assign fbFour = lvl[5];
endmodule // aic_sense_model

// >>> dv/tb.sv
`include "aic_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic er;
	int errCount = 0;
	int testsRun = 0;
	int fs = `AIC_FULL_SCALE;
	wire [31:0] prdata;
	wire pready, pslverr, sleepStop, tgtThreeWrite, tgtFourWrite;
	wire signed [15:0] r1, r2, r3, r4, fb3, fb4, monOne, monTwo, limitOne, limitTwo, speedRef;
	wire [15:0] tgtThreeId, tgtFourId;
	wire signed [31:0] tgtThreeValue, tgtFourValue;
	// clock
	always #4 clk_sys = ~clk_sys;
	aic_sense_model sens (.clk_sys(clk_sys), .rawOne(r1), .rawTwo(r2), .rawThree(r3),
		.rawFour(r4), .fbThree(fb3), .fbFour(fb4));
	aic_top #(.SAMPLE_CYCLES(8)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chanOneRaw(r1), .chanTwoRaw(r2),
		.chanThreeRaw(r3), .chanFourRaw(r4), .fbThree(fb3), .fbFour(fb4), .monOne(monOne),
		.monTwo(monTwo), .limitOne(limitOne), .limitTwo(limitTwo), .speedRef(speedRef),
		.sleepStop(sleepStop), .tgtThreeId(tgtThreeId), .tgtThreeValue(tgtThreeValue),
		.tgtThreeWrite(tgtThreeWrite), .tgtFourId(tgtFourId), .tgtFourValue(tgtFourValue),
		.tgtFourWrite(tgtFourWrite));
	task automatic testDone;
		$display("checks %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic signed [31:0] exp,
		input logic signed [31:0] got);
		testsRun++;
		if (got !== exp)
		begin
			errCount++;
			$display("unexpected %s: expected %0d seen %0d", nm, exp, got);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// no cycle count assumed; only the watchdog ends a stuck wait
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic ticks(input int n);
		repeat (n * 8) @(posedge clk_sys);
	endtask
	function automatic int lin(int x, int a, int b, int c, int d);
		return c + (x - a) * (d - c) / (b - a);
	endfunction
	function automatic int clip(int x, int lo, int hi);
		return x < lo ? lo : (x > hi ? hi : x);
	endfunction
	task automatic testRegs;
		apb(1'b0, `AIC_OFS_CUST1, 32'h0);
		chk("cust1 reset", `AIC_RST_SPAN, rd);
		apb(1'b0, 12'h050, 32'h0);
		chk("unmapped refused", 1'b1, er);
		wr(`AIC_OFS_MON, 32'h1);
		chk("read-only refused", 1'b1, er);
		$display("regs done");
	endtask
	task automatic testRanges;
		logic signed [15:0] x;
		int e;
		wr(`AIC_OFS_CUST1, 32'h1f400fa0);
		wr(`AIC_OFS_FILT, 32'h4);
		for (int r = 0; r < 4; r++)
			for (int i = 0; i < 2; i++)
			begin
				x = i ? 16'shf448 : 16'sh1770;
				e = r == 0 ? clip(x, 0, fs) : r == 1 ? clip(lin(x, `AIC_LIVE_ZERO, fs, 0, fs), 0, fs)
					: r == 2 ? clip(x, -fs, fs) : lin(x, 16'sh0fa0, 16'sh1f40, 0, fs);
				wr(`AIC_OFS_CTRL, r);
				sens.setLevel(0, x);
				ticks(3);
				chk("monOne range", e, monOne);
			end
		// custom max below min: decreasing map
		wr(`AIC_OFS_CUST1, 32'h0fa01f40);
		sens.setLevel(0, 16'sh1b58);
		ticks(3);
		chk("monOne reversed", lin(16'sh1b58, 16'sh1f40, 16'sh0fa0, 0, fs), monOne);
		wr(`AIC_OFS_CUST1, `AIC_RST_SPAN);
		$display("ranges done");
	endtask
	task automatic testFilter;
		wr(`AIC_OFS_CTRL, 32'h0);
		wr(`AIC_OFS_FILT, 32'h0333);
		wr(`AIC_OFS_TGT3LO, 32'h0);
		wr(`AIC_OFS_TGT3HI, 32'h2710);
		sens.setLevel(0, 16'sh0);
		sens.setLevel(2, 16'sh0);
		ticks(100);
		sens.setLevel(0, 16'sh1770);
		sens.setLevel(2, 16'sh1770);
		ticks(4);
		chk("limit mid", 1'b1, limitOne > 16'sh0 && limitOne < 16'sh1770);
		chk("speed lags", 1'b1, speedRef < limitOne);
		chk("ch3 mid", 1'b1, tgtThreeValue > 32'sh0 && tgtThreeValue < 32'sh1770);
		ticks(150);
		chk("limit end", 1'b1, limitOne >= 16'sh176e);
		chk("speed end", 1'b1, speedRef >= 16'sh1766);
		wr(`AIC_OFS_CTRL, 32'h100);
		ticks(2);
		chk("speed after select", 1'b1, speedRef > 16'sh03e8);
		$display("filter done");
	endtask
	task automatic testScale;
		logic signed [15:0] x;
		int e;
		wr(`AIC_OFS_CTRL, 32'h0);
		wr(`AIC_OFS_FILT, 32'h0);
		wr(`AIC_OFS_REF1, 32'h0bb803e8);
		sens.setLevel(0, 16'sh1770);
		ticks(3);
		chk("ref scaled", lin(16'sh1770, 0, fs, 16'sh03e8, 16'sh0bb8), limitOne);
		wr(`AIC_OFS_REF1, 32'h1388ec78);
		for (int i = 0; i < 4; i++)
		begin
			x = i[0] ? 16'sh1194 : 16'sh157c;
			e = lin(x, 0, fs, -16'sh1388, 16'sh1388);
			wr(`AIC_OFS_DEADB, i[1] ? 32'h0190 : 32'h0258);
			sens.setLevel(0, x);
			ticks(3);
			chk("dead band", (e < 0 ? -e : e) < (i[1] ? 400 : 600) ? 0 : e, limitOne);
		end
		wr(`AIC_OFS_REF1, `AIC_RST_SPAN);
		wr(`AIC_OFS_DEADB, 32'h0);
		$display("scale done");
	endtask
	task automatic testJoy;
		sens.setLevel(0, 16'sh1770);
		ticks(3);
		wr(`AIC_OFS_CMD, 32'h1);
		apb(1'b0, `AIC_OFS_JOYOFS, 32'h0);
		chk("offset captured", 16'sh1770, $signed(rd[15:0]));
		sens.setLevel(0, 16'sh1f40);
		ticks(3);
		chk("offset applied", 16'sh07d0, limitOne);
		wr(`AIC_OFS_CMD, 32'h4);
		apb(1'b0, `AIC_OFS_JOYOFS, 32'h0);
		chk("offset cleared", 16'sh0, $signed(rd[15:0]));
		ticks(3);
		chk("scaling kept", 16'sh1f40, limitOne);
		$display("joystick done");
	endtask
	task automatic testSleep;
		wr(`AIC_OFS_CTRL, 32'h40);
		wr(`AIC_OFS_SLPLIM, 32'h03e8);
		wr(`AIC_OFS_SLPDLY, 32'h6);
		sens.setLevel(0, 16'sh01f4);
		ticks(5);
		sens.setLevel(0, 16'sh0bb8);
		ticks(2);
		sens.setLevel(0, 16'sh01f4);
		ticks(4);
		chk("sleep restarted", 1'b0, sleepStop);
		ticks(6);
		chk("sleep stop", 1'b1, sleepStop);
		wr(`AIC_OFS_CTRL, 32'h52);
		sens.setLevel(0, 16'shfa24);
		ticks(10);
		chk("joy outside band", 1'b0, sleepStop);
		sens.setLevel(0, 16'shfe0c);
		ticks(10);
		chk("joy inside band", 1'b1, sleepStop);
		apb(1'b0, `AIC_OFS_STATUS, 32'h0);
		chk("status", 3'h5, rd[2:0]);
		wr(`AIC_OFS_CTRL, 32'h0);
		$display("sleep done");
	endtask
	task automatic testChan34;
		int v;
		wr(`AIC_OFS_TGTID, 32'h025b0063);
		wr(`AIC_OFS_TGT3LO, 32'h1b58);
		wr(`AIC_OFS_TGT3HI, 32'h32c8);
		sens.setLevel(2, 16'sh09c4);
		sens.setLevel(4, 16'sh0);
		for (int c = 0; c < 3; c++)
		begin
			wr(`AIC_OFS_CTRL, c == 0 ? 32'h0 : c == 1 ? 32'h800 : 32'ha00);
			v = c == 0 ? 16'sh09c4 : c == 1 ? fs - 16'sh09c4 : fs;
			ticks(3);
			chk("ch3 value", lin(v, 0, fs, 16'sh1b58, 16'sh32c8), tgtThreeValue);
		end
		chk("ch3 id", 16'h0063, tgtThreeId);
		chk("ch4 id", 16'h025b, tgtFourId);
		wr(`AIC_OFS_CUST4, 32'h177007d0);
		wr(`AIC_OFS_TGT4LO, 32'h0);
		wr(`AIC_OFS_TGT4HI, 32'h03e8);
		sens.setLevel(3, 16'sh0fa0);
		ticks(3);
		v = lin(16'sh0fa0, 16'sh07d0, 16'sh1770, 0, fs);
		chk("ch4 value", lin(v, 0, fs, 0, 16'sh03e8), tgtFourValue);
		// channel 2 on live zero, channel 4 from the fieldbus and inverted
		wr(`AIC_OFS_CTRL, 32'h1404);
		sens.setLevel(1, 16'sh1770);
		sens.setLevel(5, 16'sh1388);
		ticks(3);
		v = lin(16'sh1770, `AIC_LIVE_ZERO, fs, 0, fs);
		chk("monTwo live zero", v, monTwo);
		chk("limitTwo", v, limitTwo);
		wr(`AIC_OFS_CMD, 32'h2);
		apb(1'b0, `AIC_OFS_JOYOFS, 32'h0);
		chk("offset two captured", v, $signed(rd[31:16]));
		wr(`AIC_OFS_CMD, 32'h8);
		apb(1'b0, `AIC_OFS_JOYOFS, 32'h0);
		chk("offset two cleared", 0, $signed(rd[31:16]));
		v = fs - lin(16'sh1388, 16'sh07d0, 16'sh1770, 0, fs);
		chk("ch4 fieldbus", lin(v, 0, fs, 0, 16'sh03e8), tgtFourValue);
		$display("channels three four done");
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		testRegs();
		testRanges();
		testFilter();
		testScale();
		testJoy();
		testSleep();
		testChan34();
		testDone();
	end
	// watchdog well beyond the few thousand cycles the tests need
	initial
	begin
		#300us;
		errCount++;
		$display("watchdog expired");
		testDone();
	end
endmodule // tb
